// File: asb_host_model.sv
// Host model driving the register port
`timescale 1ns/1ps
module asb_host_model (
   input wire logic clk_sys,
   output logic [7:0] regAddr = 8'h00,
   output logic regWrEn = 1'b0,
   output logic [7:0] regWrData = 8'h00,
   output logic regRdEn = 1'b0,
   input wire logic [7:0] regRdData
);
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask : wr
   task automatic rd(logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk_sys);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      #1 d = regRdData;
   endtask : rd
endmodule : asb_host_model

// File: asb_in_fifo.sv
// Small input FIFO with valid and ready on both sides
`timescale 1ns/1ps
module asb_in_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
   logic full, empty, push, pop;

   assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
   assign empty = (wrPtr_reg == rdPtr_reg);
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = mem[rdPtr_reg[AW-1:0]];
   assign push = inValid && !full;
   assign pop = outReady && !empty;

   always_comb begin
      wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
      rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wrPtr_reg[AW-1:0]] <= inData;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_fifo_no_overrun: assert property (full |=> wrPtr_reg == $past(wrPtr_reg))
      else $error("input fifo written while full");
   a_fifo_no_underrun: assert property (empty |=> rdPtr_reg == $past(rdPtr_reg))
      else $error("input fifo read while empty");
endmodule : asb_in_fifo

// File: asb_pkg.sv
// Constants and types for the accelerometer sample buffer with offset correction
package asb_pkg;
   localparam logic [7:0] ADDR_OFF_X = 8'h22;
   localparam logic [7:0] ADDR_OFF_Y = 8'h23;
   localparam logic [7:0] ADDR_OFF_Z = 8'h24;
   localparam logic [7:0] ADDR_SETUP = 8'h26;
   localparam logic [7:0] RST_OFFSET = 8'h00;
   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam int BIT_ORDER = 7;
   localparam int BIT_MODE_HI = 6;
   localparam int BIT_MODE_LO = 5;
   localparam int BIT_GATE = 4;
   localparam int BIT_TRIG_WT = 3;
   localparam int BIT_TRIG_OT = 2;
   localparam int BIT_TRIG_OR = 0;
   localparam logic [7:0] LOCKED_MASK = 8'hE0;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_STREAM = 2'h1;
   localparam logic [1:0] MODE_STOP = 2'h2;
   localparam logic [1:0] MODE_TRIG = 2'h3;
   localparam int SAMPLE_W = 12;
   localparam int TRIPLET_W = 3 * SAMPLE_W;
   localparam int BUF_DEPTH = 32;
   localparam int PTR_W = 5;
   localparam int CNT_W = 6;
   localparam int WMRK_W = 6;
   localparam int GATE_CNT_W = 8;
   localparam int IN_FIFO_DEPTH = 4;
   localparam logic [SAMPLE_W-1:0] SAT_POS = 12'h7FF;
   localparam logic [SAMPLE_W-1:0] SAT_NEG = 12'h800;
   typedef enum logic [2:0] {
      ST_ARMED = 3'b001,
      ST_POST = 3'b010,
      ST_DONE = 3'b100
   } asb_trig_e;
endpackage : asb_pkg

// File: asb_sample_buffer.sv
// Offset correction and 32-triplet sample buffer with stream, stop and trigger modes
`timescale 1ns/1ps
// Function
// - Each axis has its own 8-bit signed offset register, range -128 to 127.
// - Applied offset equals the setting times two output LSBs.
// - Read-order bit clear: oldest sample is read first.
// - Read-order bit set: newest sample is read first.
// - Mode bits change only while active and trigger-pin function are clear.
// - Mode 00 disables the buffer; nothing is stored.
// - Mode 01 overwrites the oldest sample once full, keeping newest 32.
// - Mode 10 refuses new samples once full.
// - Mode 11 before trigger keeps at most watermark samples circularly.
// - After trigger accept 32 minus watermark samples, set overflow, stop.
// - Flush or full readout clears overflow and re-arms the trigger.
// - Trigger sources within, outside threshold, orientation enabled by bits 3,2,0.
// - Gate clear: power state change flushes the buffer.
// - Gate set: keep contents, discard new samples, flag and count them.
// - Flush on disable, flush command, or leaving standby.
// - Disable clears overflow, watermark, count, gate error and discard count.
module asb_sample_buffer (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   input wire logic sensorActive,
   input wire logic secondPinTriggerFunction,
   input wire logic [asb_pkg::WMRK_W-1:0] watermarkLevel,
   input wire logic flushCmd,
   input wire logic powerStateToggle,
   input wire logic evtWithinThreshold,
   input wire logic evtOutsideThreshold,
   input wire logic evtOrientChange,
   input wire logic sampleValid,
   output logic sampleReady,
   input wire logic [asb_pkg::SAMPLE_W-1:0] sampleX,
   input wire logic [asb_pkg::SAMPLE_W-1:0] sampleY,
   input wire logic [asb_pkg::SAMPLE_W-1:0] sampleZ,
   output logic outValid,
   output logic [asb_pkg::SAMPLE_W-1:0] outX,
   output logic [asb_pkg::SAMPLE_W-1:0] outY,
   output logic [asb_pkg::SAMPLE_W-1:0] outZ,
   input wire logic bufRdReq,
   output logic bufRdValid,
   output logic [asb_pkg::TRIPLET_W-1:0] bufRdData,
   output logic overflowFlag,
   output logic watermarkFlag,
   output logic [asb_pkg::CNT_W-1:0] sampleCount,
   output logic gateErrFlag,
   output logic [asb_pkg::GATE_CNT_W-1:0] gateDiscardCount,
   output logic triggered
);
   localparam int SW = asb_pkg::SAMPLE_W;
   localparam int TW = asb_pkg::TRIPLET_W;
   localparam logic [asb_pkg::CNT_W-1:0] FULL_CNT = asb_pkg::CNT_W'(asb_pkg::BUF_DEPTH);

   // Sign-extend, scale by two LSBs, add and saturate
   function automatic logic [SW-1:0] applyOffset(input logic [SW-1:0] s, input logic [7:0] o);
      logic [SW+1:0] sum;
      sum = {{2{s[SW-1]}}, s} + {{(SW-7){o[7]}}, o, 1'b0};
      if (sum[SW+1:SW-1] == 3'b000 || sum[SW+1:SW-1] == 3'b111) begin
         applyOffset = sum[SW-1:0];
      end else begin
         applyOffset = sum[SW+1] ? asb_pkg::SAT_NEG : asb_pkg::SAT_POS;
      end
   endfunction : applyOffset

   // Register file
   logic [7:0] offX_reg, offX_next, offY_reg, offY_next, offZ_reg, offZ_next;
   logic [7:0] setup_reg, setup_next, rdData_reg, rdData_next;
   logic modeLocked;

   assign modeLocked = sensorActive || secondPinTriggerFunction;

   always_comb begin
      offX_next = offX_reg;
      offY_next = offY_reg;
      offZ_next = offZ_reg;
      setup_next = setup_reg;
      rdData_next = rdData_reg;
      if (regWrEn) begin
         unique case (regAddr)
            asb_pkg::ADDR_OFF_X: offX_next = regWrData;
            asb_pkg::ADDR_OFF_Y: offY_next = regWrData;
            asb_pkg::ADDR_OFF_Z: offZ_next = regWrData;
            asb_pkg::ADDR_SETUP: begin
               setup_next = modeLocked ?
                  ((setup_reg & asb_pkg::LOCKED_MASK) | (regWrData & ~asb_pkg::LOCKED_MASK)) :
                  regWrData;
            end
            default: ;
         endcase
      end
      if (regRdEn) begin
         unique case (regAddr)
            asb_pkg::ADDR_OFF_X: rdData_next = offX_reg;
            asb_pkg::ADDR_OFF_Y: rdData_next = offY_reg;
            asb_pkg::ADDR_OFF_Z: rdData_next = offZ_reg;
            asb_pkg::ADDR_SETUP: rdData_next = setup_reg;
            default: rdData_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         offX_reg <= asb_pkg::RST_OFFSET;
         offY_reg <= asb_pkg::RST_OFFSET;
         offZ_reg <= asb_pkg::RST_OFFSET;
         setup_reg <= asb_pkg::RST_SETUP;
         rdData_reg <= 8'h00;
      end else begin
         offX_reg <= offX_next;
         offY_reg <= offY_next;
         offZ_reg <= offZ_next;
         setup_reg <= setup_next;
         rdData_reg <= rdData_next;
      end
   end
   assign regRdData = rdData_reg;

   // Offset correction and data outputs
   logic [SW-1:0] corrX, corrY, corrZ;
   logic [SW-1:0] outX_reg, outX_next, outY_reg, outY_next, outZ_reg, outZ_next;
   logic outValid_reg, outValid_next, inTake;

   assign corrX = applyOffset(sampleX, offX_reg);
   assign corrY = applyOffset(sampleY, offY_reg);
   assign corrZ = applyOffset(sampleZ, offZ_reg);
   assign inTake = sampleValid && sampleReady;

   always_comb begin
      outValid_next = inTake;
      outX_next = inTake ? corrX : outX_reg;
      outY_next = inTake ? corrY : outY_reg;
      outZ_next = inTake ? corrZ : outZ_reg;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         outValid_reg <= 1'b0;
         outX_reg <= '0;
         outY_reg <= '0;
         outZ_reg <= '0;
      end else begin
         outValid_reg <= outValid_next;
         outX_reg <= outX_next;
         outY_reg <= outY_next;
         outZ_reg <= outZ_next;
      end
   end
   assign outValid = outValid_reg;
   assign outX = outX_reg;
   assign outY = outY_reg;
   assign outZ = outZ_reg;

   // Input FIFO; drained only when no host read is pending
   logic fifoValid, drainReady, take;
   logic [TW-1:0] fifoData;

   assign drainReady = !bufRdReq;
   assign take = fifoValid && drainReady;

   asb_in_fifo #(
      .WIDTH(TW),
      .DEPTH(asb_pkg::IN_FIFO_DEPTH)
   ) u_in_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .inValid(sampleValid),
      .inReady(sampleReady),
      .inData({corrX, corrY, corrZ}),
      .outValid(fifoValid),
      .outReady(drainReady),
      .outData(fifoData)
   );

   // Sample buffer state
   logic [TW-1:0] mem [asb_pkg::BUF_DEPTH];
   logic [asb_pkg::PTR_W-1:0] wrPtr_reg, wrPtr_next, rdIdx;
   logic [asb_pkg::CNT_W-1:0] count_reg, count_next, postCnt_reg, postCnt_next;
   logic [asb_pkg::CNT_W-1:0] wmEff, postLimit;
   asb_pkg::asb_trig_e trig_reg, trig_next;
   logic ovf_reg, ovf_next, wmf_reg, wmf_next, gateClosed_reg, gateClosed_next;
   logic gateErr_reg, gateErr_next, rdValid_reg, rdValid_next;
   logic [asb_pkg::GATE_CNT_W-1:0] gateCnt_reg, gateCnt_next;
   logic [TW-1:0] rdData_q, rdDataQ_next;
   logic [1:0] mode;
   logic lifo, gateEn, lvlPrev_reg, lvlNow, standbyExit, flush, rdFire, trigEvt, memWr;

   assign mode = setup_reg[asb_pkg::BIT_MODE_HI:asb_pkg::BIT_MODE_LO];
   assign lifo = setup_reg[asb_pkg::BIT_ORDER];
   assign gateEn = setup_reg[asb_pkg::BIT_GATE];
   assign lvlNow = sensorActive || secondPinTriggerFunction;
   assign standbyExit = lvlNow && !lvlPrev_reg;
   assign flush = (mode == asb_pkg::MODE_OFF) || flushCmd || standbyExit
      || (powerStateToggle && !gateEn);
   assign rdFire = bufRdReq && (count_reg != '0);
   assign trigEvt = (evtWithinThreshold && setup_reg[asb_pkg::BIT_TRIG_WT])
      || (evtOutsideThreshold && setup_reg[asb_pkg::BIT_TRIG_OT])
      || (evtOrientChange && setup_reg[asb_pkg::BIT_TRIG_OR]);
   assign wmEff = (watermarkLevel > FULL_CNT) ? FULL_CNT : watermarkLevel;
   assign postLimit = FULL_CNT - wmEff;
   assign rdIdx = lifo ? wrPtr_reg - 1'b1 : wrPtr_reg - count_reg[asb_pkg::PTR_W-1:0];

   always_comb begin
      wrPtr_next = wrPtr_reg;
      count_next = count_reg;
      postCnt_next = postCnt_reg;
      trig_next = trig_reg;
      ovf_next = ovf_reg;
      gateClosed_next = gateClosed_reg;
      gateErr_next = gateErr_reg;
      gateCnt_next = gateCnt_reg;
      rdValid_next = 1'b0;
      rdDataQ_next = rdData_q;
      memWr = 1'b0;
      if (flush) begin
         wrPtr_next = '0;
         count_next = '0;
         postCnt_next = '0;
         trig_next = asb_pkg::ST_ARMED;
         ovf_next = 1'b0;
         gateClosed_next = 1'b0;
         gateErr_next = 1'b0;
         gateCnt_next = '0;
      end else begin
         if (rdFire) begin
            rdValid_next = 1'b1;
            rdDataQ_next = mem[rdIdx];
            count_next = count_reg - 1'b1;
            if (lifo) begin
               wrPtr_next = wrPtr_reg - 1'b1;
            end
            if (count_reg == 6'h01) begin
               ovf_next = 1'b0;
               trig_next = asb_pkg::ST_ARMED;
               postCnt_next = '0;
               gateClosed_next = 1'b0;
               gateErr_next = 1'b0;
               gateCnt_next = '0;
            end
         end
         if (powerStateToggle && gateEn) begin
            gateClosed_next = 1'b1;
         end
         if (take && gateClosed_reg) begin
            gateErr_next = 1'b1;
            if (gateCnt_reg != '1) begin
               gateCnt_next = gateCnt_reg + 1'b1;
            end
         end else if (take) begin
            unique case (mode)
               asb_pkg::MODE_STREAM: begin
                  memWr = 1'b1;
                  wrPtr_next = wrPtr_reg + 1'b1;
                  if (count_reg == FULL_CNT) begin
                     ovf_next = 1'b1;
                  end else begin
                     count_next = count_reg + 1'b1;
                  end
               end
               asb_pkg::MODE_STOP: begin
                  if (count_reg == FULL_CNT) begin
                     ovf_next = 1'b1;
                  end else begin
                     memWr = 1'b1;
                     wrPtr_next = wrPtr_reg + 1'b1;
                     count_next = count_reg + 1'b1;
                  end
               end
               asb_pkg::MODE_TRIG: begin
                  unique case (trig_reg)
                     asb_pkg::ST_ARMED: begin
                        if (wmEff != '0) begin
                           memWr = 1'b1;
                           wrPtr_next = wrPtr_reg + 1'b1;
                           if (count_reg < wmEff) begin
                              count_next = count_reg + 1'b1;
                           end
                        end
                     end
                     asb_pkg::ST_POST: begin
                        memWr = 1'b1;
                        wrPtr_next = wrPtr_reg + 1'b1;
                        count_next = count_reg + 1'b1;
                        postCnt_next = postCnt_reg + 1'b1;
                        if (postCnt_reg + 1'b1 >= postLimit) begin
                           trig_next = asb_pkg::ST_DONE;
                           ovf_next = 1'b1;
                        end
                     end
                     asb_pkg::ST_DONE: ;
                     default: trig_next = asb_pkg::ST_ARMED;
                  endcase
               end
               default: ;
            endcase
         end
         if (mode == asb_pkg::MODE_TRIG && trig_reg == asb_pkg::ST_ARMED && trigEvt) begin
            trig_next = (postLimit == '0) ? asb_pkg::ST_DONE : asb_pkg::ST_POST;
            ovf_next = ovf_next || (postLimit == '0);
         end
      end
      wmf_next = (watermarkLevel != '0) && (count_next >= watermarkLevel);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_reg <= '0;
         count_reg <= '0;
         postCnt_reg <= '0;
         trig_reg <= asb_pkg::ST_ARMED;
         ovf_reg <= 1'b0;
         wmf_reg <= 1'b0;
         gateClosed_reg <= 1'b0;
         gateErr_reg <= 1'b0;
         gateCnt_reg <= '0;
         rdValid_reg <= 1'b0;
         rdData_q <= '0;
         lvlPrev_reg <= 1'b0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         count_reg <= count_next;
         postCnt_reg <= postCnt_next;
         trig_reg <= trig_next;
         ovf_reg <= ovf_next;
         wmf_reg <= wmf_next;
         gateClosed_reg <= gateClosed_next;
         gateErr_reg <= gateErr_next;
         gateCnt_reg <= gateCnt_next;
         rdValid_reg <= rdValid_next;
         rdData_q <= rdDataQ_next;
         lvlPrev_reg <= lvlNow;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (memWr) begin
         mem[wrPtr_reg] <= fifoData;
      end
   end

   assign bufRdValid = rdValid_reg;
   assign bufRdData = rdData_q;
   assign overflowFlag = ovf_reg;
   assign watermarkFlag = wmf_reg;
   assign sampleCount = count_reg;
   assign gateErrFlag = gateErr_reg;
   assign gateDiscardCount = gateCnt_reg;
   assign triggered = (trig_reg != asb_pkg::ST_ARMED);

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic quiet;
   assign quiet = !flush && !rdFire && !gateClosed_reg;
   sequence sPostStep;
      trig_reg == asb_pkg::ST_POST && take && !flush && !gateClosed_reg;
   endsequence
   sequence sReachDone;
      trig_reg == asb_pkg::ST_DONE;
   endsequence

   a_offset_store: assert property (
      regWrEn && regAddr == asb_pkg::ADDR_OFF_Y |=> offY_reg == $past(regWrData))
      else $error("offset write not stored");
   a_offset_applied: assert property (
      inTake |=> outValid && outX == applyOffset($past(sampleX), $past(offX_reg)))
      else $error("corrected output wrong");
   a_fifo_order_ptr: assert property (
      rdFire && !lifo && !flush |=> bufRdValid && wrPtr_reg == $past(wrPtr_reg))
      else $error("oldest-first read moved write pointer");
   a_lifo_order_ptr: assert property (
      rdFire && lifo && !flush |=> wrPtr_reg == $past(wrPtr_reg) - 1'b1)
      else $error("newest-first read did not step back");
   a_mode_lock: assert property (
      modeLocked |=> (setup_reg & asb_pkg::LOCKED_MASK)
      == ($past(setup_reg) & asb_pkg::LOCKED_MASK))
      else $error("mode changed while locked");
   a_disable_empty: assert property (
      mode == asb_pkg::MODE_OFF |=> count_reg == '0 && !ovf_reg)
      else $error("disabled buffer holds samples");
   a_stream_overwrite: assert property (
      mode == asb_pkg::MODE_STREAM && count_reg == FULL_CNT && take && quiet
      |=> count_reg == FULL_CNT && wrPtr_reg == $past(wrPtr_reg) + 1'b1 && ovf_reg)
      else $error("stream did not overwrite oldest");
   a_stop_refuse: assert property (
      mode == asb_pkg::MODE_STOP && count_reg == FULL_CNT && take && quiet
      |=> count_reg == FULL_CNT && wrPtr_reg == $past(wrPtr_reg))
      else $error("stop mode accepted sample when full");
   a_pretrig_cap: assert property (
      mode == asb_pkg::MODE_TRIG && trig_reg == asb_pkg::ST_ARMED && take && quiet
      && count_reg <= wmEff |=> count_reg <= $past(wmEff))
      else $error("pre-trigger history exceeds watermark");
   a_post_done_ovf: assert property (
      sPostStep ##1 sReachDone |-> ovf_reg)
      else $error("post-trigger stop without overflow");
   a_rearm_readout: assert property (
      rdFire && count_reg == 6'h01 && !flush |=> !ovf_reg && trig_reg == asb_pkg::ST_ARMED)
      else $error("trigger not re-armed after readout");
   a_trigger_on_orientation_change: assert property (
      mode == asb_pkg::MODE_TRIG && trig_reg == asb_pkg::ST_ARMED && !flush
      && evtOrientChange && setup_reg[asb_pkg::BIT_TRIG_OR] |=> triggered)
      else $error("enabled trigger source ignored");
   a_power_flush: assert property (
      powerStateToggle && !gateEn |=> count_reg == '0)
      else $error("power change did not flush");
   a_gate_discard: assert property (
      gateClosed_reg && take && !flush && !rdFire
      |=> gateErrFlag && count_reg == $past(count_reg))
      else $error("gated sample not discarded");
   a_flush_cmd: assert property (
      flushCmd || standbyExit |=> count_reg == '0 && wrPtr_reg == '0)
      else $error("flush did not empty buffer");
   a_disable_clear: assert property (
      mode == asb_pkg::MODE_OFF |=> !wmf_reg && !gateErr_reg && gateCnt_reg == '0)
      else $error("disable left status set");
endmodule : asb_sample_buffer

// File: asb_sample_buffer_test.sv
// Self-checking bench for offset correction and the sample buffer
`timescale 1ns/1ps
module asb_sample_buffer_test;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] regAddr, regWrData, regRdData, rdv, gateDiscardCount;
   logic regWrEn, regRdEn, sampleReady, outValid, bufRdValid, overflowFlag;
   logic watermarkFlag, gateErrFlag, triggered;
   logic sensorActive = 1'b0;
   logic secondPinTriggerFunction = 1'b0;
   logic sampleValid = 1'b0;
   logic bufRdReq = 1'b0;
   logic [4:0] pulses = 5'h00;
   wire flushCmd, powerStateToggle, evtWithinThreshold, evtOutsideThreshold, evtOrientChange;
   logic [5:0] watermarkLevel = 6'h00;
   logic [5:0] sampleCount;
   logic [11:0] sampleX = 12'h000, sampleY = 12'h000, sampleZ = 12'h000;
   logic [11:0] outX, outY, outZ;
   logic [35:0] bufRdData;
   logic [7:0] offs [3];
   logic [35:0] smp [64];
   int num_errors = 0;
   int cmp_count = 0;
   assign {flushCmd, powerStateToggle, evtWithinThreshold, evtOutsideThreshold,
      evtOrientChange} = pulses;
   asb_sample_buffer DUT (.*);
   asb_host_model host (.*);
   always #5 clk_sys = ~clk_sys;
   task automatic chk(logic ok, string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic stop_test();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   function automatic logic [11:0] corr(logic [11:0] s, logic [7:0] o);
      logic signed [13:0] v;
      v = $signed({{2{s[11]}}, s}) + $signed({{5{o[7]}}, o, 1'b0});
      return v > 14'sh07FF ? 12'h7FF : v < -14'sh0800 ? 12'h800 : v[11:0];
   endfunction : corr
   function automatic logic [35:0] ex(int i);
      return {corr(smp[i][35:24], offs[0]), corr(smp[i][23:12], offs[1]),
         corr(smp[i][11:0], offs[2])};
   endfunction : ex
   task automatic push(int i);
      int k = 0;
      @(posedge clk_sys);
      {sampleX, sampleY, sampleZ} <= smp[i];
      sampleValid <= 1'b1;
      do @(negedge clk_sys); while (sampleReady !== 1'b1 && ++k < 20);
      if (k >= 20) begin
         chk(1'b0, "ready timeout");
         stop_test();
      end
      @(posedge clk_sys);
      sampleValid <= 1'b0;
      #1;
      for (k = 0; k < 3 && outValid !== 1'b1; k++) #10;
      chk(outValid === 1'b1 && {outX, outY, outZ} === ex(i), "out");
   endtask : push
   task automatic wcnt(logic [5:0] n);
      int k;
      repeat (3) @(negedge clk_sys);
      for (k = 0; k < 60 && sampleCount !== n; k++) @(negedge clk_sys);
      chk(sampleCount === n, "count");
      if (sampleCount !== n) stop_test();
   endtask : wcnt
   task automatic pop(logic [35:0] e);
      @(posedge clk_sys);
      bufRdReq <= 1'b1;
      @(posedge clk_sys);
      bufRdReq <= 1'b0;
      #1 chk(bufRdValid === 1'b1 && bufRdData === e, "pop");
   endtask : pop
   task automatic pls(logic [4:0] p);
      @(posedge clk_sys);
      pulses <= p;
      @(posedge clk_sys);
      pulses <= 5'h00;
      @(negedge clk_sys);
   endtask : pls
   initial begin
      int i, j, w;
      void'($urandom(32'h780388C2));
      for (i = 0; i < 64; i++) smp[i] = {$urandom(), 4'($urandom())};
      smp[0] = 36'h7FF800000;
      offs = '{8'h7F, 8'h80, 8'($urandom())};
      w = $urandom_range(8, 1);
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      watermarkLevel <= 6'(w);
      for (i = 0; i < 6; i++) begin
         host.rd(8'h21 + 8'(i), rdv);
         chk(rdv === 8'h00, "reset");
         if (i > 0 && i < 4) begin
            host.wr(8'h21 + 8'(i), offs[i - 1]);
            host.rd(8'h21 + 8'(i), rdv);
            chk(rdv === offs[i - 1], "offset");
         end
      end
      push(0);
      push(1);
      wcnt(0);
      @(posedge clk_sys);
      bufRdReq <= 1'b1;
      for (i = 0; i < 4; i++) push(i);
      chk(sampleReady === 1'b0, "fifo full");
      @(posedge clk_sys);
      bufRdReq <= 1'b0;
      for (i = 1; i < 3; i++) begin
         @(posedge clk_sys);
         {sensorActive, secondPinTriggerFunction} <= 2'(i);
         host.wr(8'h26, 8'h48);
         host.rd(8'h26, rdv);
         chk(rdv === 8'h08, "lock");
      end
      @(posedge clk_sys);
      {sensorActive, secondPinTriggerFunction} <= 2'b00;
      host.wr(8'h26, 8'h20);
      for (i = 0; i < 34; i++) push(i);
      wcnt(32);
      chk(overflowFlag === 1'b1, "stream");
      for (i = 2; i < 34; i++) pop(ex(i));
      host.wr(8'h26, 8'h00);
      host.wr(8'h26, 8'hC0);
      for (i = 0; i < 33; i++) push(i);
      wcnt(32);
      chk(overflowFlag === 1'b1 && watermarkFlag === 1'b1, "stop");
      pop(ex(31));
      pop(ex(30));
      host.wr(8'h26, 8'h00);
      wcnt(0);
      chk(overflowFlag === 1'b0 && watermarkFlag === 1'b0, "disable");
      for (j = 0; j < 2; j++) begin
         host.wr(8'h26, 8'h20 | 8'(j << 4));
         for (i = 0; i < 3; i++) push(i);
         wcnt(3);
         pls(5'h08);
      end
      push(3);
      push(4);
      wcnt(3);
      chk(gateErrFlag === 1'b1 && gateDiscardCount === 8'h02, "gate");
      pls(5'h10);
      wcnt(0);
      chk(gateErrFlag === 1'b0 && gateDiscardCount === 8'h00, "ungate");
      for (j = 0; j < 3; j++) begin
         host.wr(8'h26, 8'h00);
         host.wr(8'h26, 8'h60 | (j == 2 ? 8'h01 : 8'h08 >> j));
         for (i = 0; i < w + 2; i++) push(i);
         wcnt(6'(w));
         pls({2'b00, ~(3'b100 >> j)});
         chk(triggered === 1'b0, "off source");
         pls({2'b00, 3'b100 >> j});
         chk(triggered === 1'b1, "trigger");
         for (i = 10; i < 44 - w; i++) push(i);
         wcnt(32);
         chk(overflowFlag === 1'b1, "post");
         for (i = 0; i < 32 && j == 0; i++) pop(ex(i < w ? i + 2 : i - w + 10));
         if (j > 0) pls(5'h10);
         wcnt(0);
         chk(overflowFlag === 1'b0 && triggered === 1'b0, "rearm");
      end
      stop_test();
   end
endmodule : asb_sample_buffer_test
